// ---- usst_pkg.sv ----
package usst_pkg;
   localparam int          USST_W          = 8;
   localparam int          USST_TRANSMIT_READY_POS  = 0;
   localparam int          USST_RECEIVE_READY_POS  = 1;
   localparam int          USST_TXEMT_POS  = 2;
   localparam int          USST_PAR_POS    = 3;
   localparam int          USST_OVR_POS    = 4;
   localparam int          USST_FRM_POS    = 5;
   localparam int          USST_DCD_POS    = 6;
   localparam int          USST_DSR_POS    = 7;
   localparam logic [7:0]  USST_SR_RESET   = 8'h00;
   localparam logic [1:0]  USST_STOP_1     = 2'h1;
   localparam logic [1:0]  USST_STOP_1P5   = 2'h2;
   localparam logic [1:0]  USST_STOP_2     = 2'h3;
endpackage

// ---- usst_sync2.sv ----
module usst_sync2
   import usst_pkg::*;
#(
   parameter int W = 2
) (
   input  wire logic         sys_clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_q;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= '1;
         q_out  <= '1;
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule

// ---- usst_status.sv ----
// Operation
// - overrun on load while holding unread
// - overrun cleared by disable or reset-error
// - async framing error on bad stop
// - 1.5 stop: check first stop only
// - framing error plus zero char: break
// - non-transparent sync sets sync flag
// - transparent: initial sync, then escape-sync
// - sync flag clears: disable, async reset, sync read
// - carrier and set-ready read inverted
// - parity flag set, cleared like overrun
// - receive ready set on load, cleared on read
// - transmit ready while holding register free and transmit enabled
// - modem change cleared by status read
module usst_status
   import usst_pkg::*;
(
   input  wire logic              sys_clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              sync_mode_in,
   input  wire logic              transparent_select_in,
   input  wire logic              parity_enable_bit_in,
   input  wire logic [1:0]        stop_bits_in,
   input  wire logic              rx_enable_in,
   input  wire logic              tx_enable_in,
   input  wire logic              clear_errors_command_in,
   input  wire logic              rx_load_in,
   input  wire logic [USST_W-1:0] rx_char_in,
   input  wire logic              rx_stop1_ok_in,
   input  wire logic              rx_stop2_ok_in,
   input  wire logic              rx_parity_err_in,
   input  wire logic              rx_sync_detect_in,
   input  wire logic              rx_escape_sync_in,
   input  wire logic              rx_escape_in,
   input  wire logic              rhr_read_in,
   input  wire logic              sr_read_in,
   input  wire logic              thr_load_in,
   input  wire logic              thr_xfer_in,
   input  wire logic              tsr_done_in,
   input  wire logic              dcd_n_in,
   input  wire logic              dsr_n_in,
   output logic [USST_W-1:0]      line_and_modem_status_out,
   output logic                   break_detect_out
);
   ////////////////////////////////////////////////////////////////////////
   // reset release and modem sync
   logic       rst_s1_q;
   logic       rst_s2_q;
   logic [1:0] modem_s;
   logic [1:0] modem_prev_q;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   wire rst_n = rst_s2_q;

   usst_sync2 #(.W(2)) u_modem_sync (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n),
      .d_in       ({dsr_n_in, dcd_n_in}),
      .q_out      (modem_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // decode of events
   logic              transmit_ready_q;
   logic              receive_ready_q;
   logic              tx_empty_q;
   logic              modem_change_q;
   logic              parity_or_escape_flag_q;
   logic              overrun_flag_q;
   logic              framing_or_sync_flag_q;
   logic              synced_q;
   logic [USST_W-1:0] receive_holding_register_q;
   logic              transmit_ready_d;
   logic              receive_ready_d;
   logic              tx_empty_d;
   logic              modem_change_d;
   logic              parity_d;
   logic              overrun_d;
   logic              framing_d;
   logic              synced_d;
   logic              break_d;
   logic [USST_W-1:0] receive_holding_register_d;
   logic [USST_W-1:0] status_d;

   // flag update, set wins over clear
   function automatic logic flag_next(input logic set, input logic clr, input logic cur);
      if (set) begin
         return 1'b1;
      end else if (clr) begin
         return 1'b0;
      end
      return cur;
   endfunction

   wire rx_off       = !rx_enable_in;
   wire err_clr      = clear_errors_command_in;
   wire async_rx     = rx_load_in && !sync_mode_in;
   wire stop_bad     = !rx_stop1_ok_in || ((stop_bits_in == USST_STOP_2) && !rx_stop2_ok_in);
   wire frame_evt    = async_rx && stop_bad;
   wire first_sync   = sync_mode_in && rx_sync_detect_in && (!transparent_select_in || !synced_q);
   wire escape_sync  = sync_mode_in && transparent_select_in && synced_q && rx_escape_sync_in;
   wire sync_evt     = first_sync || escape_sync;
   wire parity_evt   = rx_load_in && parity_enable_bit_in && rx_parity_err_in;
   wire escape_evt   = rx_load_in && sync_mode_in && transparent_select_in && !parity_enable_bit_in
                       && rx_escape_in;
   wire par_evt      = parity_evt || escape_evt;
   wire ovr_evt      = rx_load_in && receive_ready_q && !rhr_read_in;
   wire err_flag_clr = rx_off || err_clr;
   wire frm_clr      = rx_off || (!sync_mode_in && err_clr) || (sync_mode_in && sr_read_in);
   wire modem_edge   = (modem_s != modem_prev_q) && (tx_enable_in || rx_enable_in);
   wire rhr_zero     = (receive_holding_register_d == '0);

   ////////////////////////////////////////////////////////////////////////
   // next values
   assign overrun_d                  = flag_next(ovr_evt, err_flag_clr, overrun_flag_q);
   assign parity_d                   = flag_next(par_evt, err_flag_clr, parity_or_escape_flag_q);
   assign framing_d                  = flag_next(frame_evt || sync_evt, frm_clr, framing_or_sync_flag_q);
   assign synced_d                   = rx_off ? 1'b0 : (synced_q || (sync_mode_in && rx_sync_detect_in));
   assign receive_ready_d            = flag_next(rx_load_in, rhr_read_in || rx_off, receive_ready_q);
   assign receive_holding_register_d = rx_load_in ? rx_char_in : receive_holding_register_q;
   assign transmit_ready_d           = thr_load_in ? 1'b0 : (thr_xfer_in || transmit_ready_q);
   assign tx_empty_d                 = thr_load_in ? 1'b0 : (tsr_done_in || tx_empty_q);
   assign modem_change_d             = flag_next(modem_edge, sr_read_in, modem_change_q);
   assign break_d                    = framing_d && rhr_zero && !sync_mode_in;

   assign status_d[USST_TRANSMIT_READY_POS]   = transmit_ready_d && tx_enable_in;
   assign status_d[USST_RECEIVE_READY_POS]   = receive_ready_d;
   assign status_d[USST_TXEMT_POS]   = tx_empty_d || modem_change_d;
   assign status_d[USST_PAR_POS]     = parity_d;
   assign status_d[USST_OVR_POS]     = overrun_d;
   assign status_d[USST_FRM_POS]     = framing_d;
   assign status_d[USST_DCD_POS]     = ~modem_s[0];
   assign status_d[USST_DSR_POS]     = ~modem_s[1];

   ////////////////////////////////////////////////////////////////////////
   // transmit side registers
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         transmit_ready_q <= 1'b1;
      end else begin
         transmit_ready_q <= transmit_ready_d;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tx_empty_q <= 1'b0;
      end else begin
         tx_empty_q <= tx_empty_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive side registers
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         receive_ready_q <= 1'b0;
      end else begin
         receive_ready_q <= receive_ready_d;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         receive_holding_register_q <= 8'h00;
      end else begin
         receive_holding_register_q <= receive_holding_register_d;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         synced_q <= 1'b0;
      end else begin
         synced_q <= synced_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // error flags
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         overrun_flag_q <= 1'b0;
      end else begin
         overrun_flag_q <= overrun_d;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         parity_or_escape_flag_q <= 1'b0;
      end else begin
         parity_or_escape_flag_q <= parity_d;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         framing_or_sync_flag_q <= 1'b0;
      end else begin
         framing_or_sync_flag_q <= framing_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // modem change tracking
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         modem_change_q <= 1'b0;
         modem_prev_q   <= 2'h3;
      end else begin
         modem_change_q <= modem_change_d;
         modem_prev_q   <= modem_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         line_and_modem_status_out <= USST_SR_RESET;
         break_detect_out          <= 1'b0;
      end else begin
         line_and_modem_status_out <= status_d;
         break_detect_out          <= break_d;
      end
   end
endmodule

// ---- usst_status_assertions.sv ----
module usst_status_chk
   import usst_pkg::*;
(
   input wire logic              sys_clk_in, rst_n_in, sync_mode_in, rx_enable_in, tx_enable_in, rx_load_in,
   input wire logic              clear_errors_command_in, rx_stop1_ok_in, rhr_read_in, thr_load_in, thr_xfer_in,
   input wire logic              dcd_n_in,
   input wire logic [USST_W-1:0] line_and_modem_status_out
);
   wire [7:0] s = line_and_modem_status_out;
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   overrun_set_a: assert property (rx_load_in && s[1] |=> s[4]) else $error("overrun missed");
   ready_set_a: assert property (rx_load_in |=> s[1]) else $error("rx ready missed");
   error_clear_a: assert property (clear_errors_command_in && !rx_load_in |=> !s[3] && !s[4]) else $error("kept");
   disable_clear_a: assert property (!rx_enable_in && !rx_load_in |=> !s[1] && !s[4]) else $error("kept");
   holding_read_a: assert property (rhr_read_in && !rx_load_in |=> !s[1]) else $error("rx ready kept");
   framing_set_a: assert property (!sync_mode_in && rx_load_in && !rx_stop1_ok_in |=> s[5]) else $error("no frame");
   carrier_low_a: assert property ($fell(dcd_n_in) ##1 !dcd_n_in [*2] |=> s[6]) else $error("carrier");
   tx_busy_a: assert property (tx_enable_in && thr_load_in && !thr_xfer_in |=> !s[0]) else $error("tx ready");
   overrun_c: cover property (s[4]);
   framing_c: cover property (!sync_mode_in && s[5]);
   sync_c: cover property (sync_mode_in && s[5]);
endmodule

// ---- usst_cpu_model.sv ----
module usst_cpu_model (
   input  wire logic       sys_clk_in,
   output logic      [3:0] strobe_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial strobe_out = 4'h0;
   // status read anytime
   // strobe: 0 holding read, 1 status read, 2 clear errors, 3 transmit load
   task automatic strobe(input logic [1:0] sel);
      @(posedge sys_clk_in);
      strobe_out <= 4'h1 << sel;
      @(posedge sys_clk_in);
      strobe_out <= 4'h0;
   endtask
endmodule

// ---- usst_status_bench.sv ----
module usst_status_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import usst_pkg::*;
   logic sys_clk_in = 0, rst_n_in = 0, sync_mode_in = 0, transparent_select_in = 0, parity_enable_bit_in = 1;
   logic rx_enable_in = 1, tx_enable_in = 1, rx_load_in = 0, rx_stop1_ok_in = 1, rx_stop2_ok_in = 1;
   logic rx_parity_err_in = 0, rx_sync_detect_in = 0, rx_escape_sync_in = 0, rx_escape_in = 0, thr_xfer_in = 0;
   logic tsr_done_in = 0, dcd_n_in = 1, dsr_n_in = 1, break_detect_out;
   logic rhr_read_in, sr_read_in, clear_errors_command_in, thr_load_in;
   logic [1:0] stop_bits_in = USST_STOP_1;
   logic [7:0] rx_char_in = 8'h00, line_and_modem_status_out;
   logic [3:0] stb;
   int   errors = 0, samples_checked = 0;
   always #5 sys_clk_in = ~sys_clk_in;
   assign {thr_load_in, clear_errors_command_in, sr_read_in, rhr_read_in} = stb;
   usst_cpu_model usst_cpu_model_inst (.sys_clk_in, .strobe_out(stb));
   usst_status usst_status_inst (.*);
   task automatic check(input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic look(input logic [7:0] e);
      #1 check(line_and_modem_status_out, e);
   endtask
   task automatic rx(input logic [7:0] c, input logic s1, pe, input logic [7:0] e);
      @(posedge sys_clk_in);
      {rx_load_in, rx_char_in, rx_stop1_ok_in, rx_stop2_ok_in, rx_parity_err_in} <= {1'b1, c, s1, ~s1, pe};
      @(posedge sys_clk_in);
      rx_load_in <= 1'b0;
      look(e);
   endtask
   task automatic cpu(input logic [1:0] sel, input logic [7:0] e);
      usst_cpu_model_inst.strobe(sel);
      look(e);
   endtask
   task automatic print_verdict;
      if (errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      look(8'h01);
      rx(8'h41, 1'b1, 1'b0, 8'h03);
      rx(8'h42, 1'b1, 1'b1, 8'h1B);
      cpu(2'h2, 8'h03);
      cpu(2'h0, 8'h01);
      @(posedge sys_clk_in);
      stop_bits_in <= USST_STOP_1P5;
      rx(8'h55, 1'b1, 1'b0, 8'h03);
      cpu(2'h0, 8'h01);
      rx(8'h00, 1'b0, 1'b0, 8'h23);
      check({7'h00, break_detect_out}, 8'h01);
      cpu(2'h2, 8'h03);
      rx(8'h01, 1'b1, 1'b0, 8'h13);
      @(posedge sys_clk_in);
      rx_enable_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      look(8'h01);
      @(posedge sys_clk_in);
      rx_enable_in <= 1'b1;
      sync_mode_in <= 1'b1;
      @(posedge sys_clk_in);
      rx_sync_detect_in <= 1'b1;
      @(posedge sys_clk_in);
      rx_sync_detect_in <= 1'b0;
      look(8'h21);
      cpu(2'h1, 8'h01);
      @(posedge sys_clk_in);
      {dcd_n_in, dsr_n_in} <= 2'h0;
      repeat (5) @(posedge sys_clk_in);
      look(8'hC5);
      cpu(2'h1, 8'hC1);
      cpu(2'h3, 8'hC0);
      @(posedge sys_clk_in);
      thr_xfer_in <= 1'b1;
      @(posedge sys_clk_in);
      {thr_xfer_in, tsr_done_in} <= 2'b01;
      @(posedge sys_clk_in);
      tsr_done_in <= 1'b0;
      look(8'hC5);
      @(posedge sys_clk_in);
      {transparent_select_in, rx_escape_sync_in} <= 2'b11;
      @(posedge sys_clk_in);
      rx_escape_sync_in <= 1'b0;
      look(8'hE5);
      print_verdict();
   end
   initial begin
      #5000;
      errors++;
      print_verdict();
   end
endmodule
bind usst_status usst_status_chk usst_status_chk_inst (.*);
